//--- hw/ldm_mux.sv
// ldm_mux: display ram write pointer, byte placement and backplane scan.
// assumes: display bytes and pointer loads come in as synchronous strobes
// from a bus front end; outputs are logic levels for the analog drivers.
// Behaviour
// - drive first 8, 6 or 4 backplanes per mode; others stay idle
// - up to 44 segment outputs from scan timing and held data
// - active segments 0-39, 0-41, 0-43 by mode; general outputs displace segments
// - any combination of six general outputs, each removing only its segment
// - stored one selects on waveform, zero selects off waveform
// - column maps to segment, row maps to backplane during its slot
// - display data held in register while scan runs
// - bytes stored as they arrive in 4, 6 or 8 bit units
// - host loads pointer first; next byte lands at the pointer column
// - pointer advances two, one-or-two, or one columns per byte by mode
// - pointer stops at end; excess bits and bytes discarded until reload
// - in 1:4 a byte fills two columns; 22 bytes fill memory
// - in 1:4 bits past the end are dropped
// - in 1:6 a byte fills a column and wraps two bits onward
// - in 1:8 a byte fills one column; 40 bytes fill memory
// - reset clears all registers except the byte buffer data, and keeps display memory
`timescale 1ns/1ps
`default_nettype none
module ldm_mux #(
	parameter int SLOT_CYCLES = ldm_pkg::SLOT_CYC
) (
	input  wire logic                          ref_clk,
	input  wire logic                          resetn,
	input  wire logic [2:0]                    mux_mode,
	input  wire logic                          ptr_load,
	input  wire logic [ldm_pkg::PTR_W-1:0]     ptr_value,
	input  wire logic                          byte_valid,
	output logic                               byte_ready,
	input  wire logic [7:0]                    byte_data,
	input  wire logic [ldm_pkg::NUM_GP-1:0]    general_enable,
	input  wire logic [ldm_pkg::NUM_GP-1:0]    general_level,
	output logic [ldm_pkg::NUM_BP-1:0]         backplane_out,
	output logic [ldm_pkg::NUM_SEG-1:0]        segment_out,
	output logic [ldm_pkg::NUM_SEG-1:0]        segment_active,
	output logic [ldm_pkg::NUM_GP-1:0]         general_out,
	output logic [ldm_pkg::PTR_W-1:0]          write_pointer
);
	// ==========================================================
	// mode decode helpers
	function automatic logic [5:0] cols_of(input logic [2:0] m);
		case (m)
			ldm_pkg::LDM_MUX4: cols_of = 6'(ldm_pkg::COLS_MUX4);
			ldm_pkg::LDM_MUX6: cols_of = 6'(ldm_pkg::COLS_MUX6);
			default:           cols_of = 6'(ldm_pkg::COLS_MUX8);
		endcase
	endfunction
	function automatic logic [3:0] rows_of(input logic [2:0] m);
		case (m)
			ldm_pkg::LDM_MUX4: rows_of = 4'(ldm_pkg::ROWS_MUX4);
			ldm_pkg::LDM_MUX6: rows_of = 4'(ldm_pkg::ROWS_MUX6);
			default:           rows_of = 4'(ldm_pkg::ROWS_MUX8);
		endcase
	endfunction
	logic [5:0] num_cols;
	logic [3:0] num_rows;
	assign num_cols = cols_of(mux_mode);
	assign num_rows = rows_of(mux_mode);

	// ==========================================================
	// two-entry input buffer so a busy writer loses no byte
	logic [7:0] buf_data_r [2];
	logic [7:0] buf_data_nxt [2];
	logic [1:0] buf_cnt_r;
	logic [1:0] buf_cnt_nxt;
	logic       buf_rd_ptr_r;
	logic       buf_rd_ptr_nxt;
	logic       buf_wr_ptr_r;
	logic       buf_wr_ptr_nxt;
	logic       buf_valid;
	logic       buf_pop;
	logic       buf_push;
	assign byte_ready = (buf_cnt_r != 2'h2);
	assign buf_valid  = (buf_cnt_r != 2'h0);
	assign buf_push   = byte_valid && byte_ready;
	always_comb begin
		buf_data_nxt   = buf_data_r;
		buf_wr_ptr_nxt = buf_wr_ptr_r;
		buf_rd_ptr_nxt = buf_rd_ptr_r;
		buf_cnt_nxt    = buf_cnt_r;
		if (buf_push) begin
			buf_data_nxt[buf_wr_ptr_r] = byte_data;
			buf_wr_ptr_nxt = ~buf_wr_ptr_r;
		end
		if (buf_pop)
			buf_rd_ptr_nxt = ~buf_rd_ptr_r;
		if (ptr_load) begin  // a new pointer drops stale bytes
			buf_cnt_nxt    = 2'h0;
			buf_rd_ptr_nxt = 1'b0;
			buf_wr_ptr_nxt = 1'b0;
		end else
			buf_cnt_nxt = buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			buf_cnt_r    <= 2'h0;
			buf_rd_ptr_r <= 1'b0;
			buf_wr_ptr_r <= 1'b0;
		end else begin
			buf_cnt_r    <= buf_cnt_nxt;
			buf_rd_ptr_r <= buf_rd_ptr_nxt;
			buf_wr_ptr_r <= buf_wr_ptr_nxt;
		end
		buf_data_r <= buf_data_nxt;
	end

	// ==========================================================
	// write engine: one bit per cycle, msb first into rows then columns
	ldm_pkg::ldm_state_e    st_r;
	ldm_pkg::ldm_state_e    st_nxt;
	logic [5:0]             col_r;
	logic [5:0]             col_nxt;
	logic [2:0]             row_r;
	logic [2:0]             row_nxt;
	logic [2:0]             bit_r;
	logic [2:0]             bit_nxt;
	logic [7:0]             sh_r;
	logic [7:0]             sh_nxt;
	logic                   wr_en;
	logic                   at_end;
	assign at_end = (col_r >= num_cols);
	always_comb begin
		st_nxt  = st_r;
		col_nxt = col_r;
		row_nxt = row_r;
		bit_nxt = bit_r;
		sh_nxt  = sh_r;
		wr_en   = 1'b0;
		buf_pop = 1'b0;
		case (st_r)
			ldm_pkg::LDM_IDLE: begin
				if (buf_valid && !ptr_load) begin
					buf_pop = 1'b1;
					sh_nxt  = buf_data_r[buf_rd_ptr_r];
					bit_nxt = 3'h0;
					st_nxt  = ldm_pkg::LDM_WRITE;
				end
			end
			ldm_pkg::LDM_WRITE: begin
				wr_en  = !at_end;
				sh_nxt = {sh_r[6:0], 1'b0};
				bit_nxt = bit_r + 3'h1;
				if (!at_end) begin
					if ({1'b0, row_r} == num_rows - 4'h1) begin
						row_nxt = 3'h0;
						col_nxt = col_r + 6'h01;
					end else
						row_nxt = row_r + 3'h1;
				end
				if (bit_r == 3'h7)
					st_nxt = ldm_pkg::LDM_IDLE;
			end
			default: st_nxt = ldm_pkg::LDM_IDLE;
		endcase
		if (ptr_load) begin
			st_nxt  = ldm_pkg::LDM_IDLE;
			col_nxt = ptr_value;
			row_nxt = 3'h0;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_r  <= ldm_pkg::LDM_IDLE;
			col_r <= ldm_pkg::PTR_RST;
			row_r <= 3'h0;
			bit_r <= 3'h0;
			sh_r  <= 8'h00;
		end else begin
			st_r  <= st_nxt;
			col_r <= col_nxt;
			row_r <= row_nxt;
			bit_r <= bit_nxt;
			sh_r  <= sh_nxt;
		end
	end
	assign write_pointer = col_r;

	// ==========================================================
	// display memory, not reset
	logic [ldm_pkg::NUM_SEG*ldm_pkg::NUM_BP-1:0] image;
	ldm_ram #(
		.COLS (ldm_pkg::NUM_SEG),
		.ROWS (ldm_pkg::NUM_BP)
	) u_ram (
		.ref_clk (ref_clk),
		.wr_en   (wr_en),
		.wr_col  (col_r),
		.wr_row  (row_r),
		.wr_bit  (sh_r[7]),
		.image   (image)
	);

	// ==========================================================
	// backplane scan: slot timer and ascending row counter
	logic [$clog2(SLOT_CYCLES+1)-1:0] slot_r;
	logic [$clog2(SLOT_CYCLES+1)-1:0] slot_nxt;
	logic [2:0]                       scan_r;
	logic [2:0]                       scan_nxt;
	always_comb begin
		slot_nxt = slot_r + 1'b1;
		scan_nxt = scan_r;
		if (int'(slot_r) >= SLOT_CYCLES - 1) begin
			slot_nxt = '0;
			if ({1'b0, scan_r} >= num_rows - 4'h1)
				scan_nxt = 3'h0;
			else
				scan_nxt = scan_r + 3'h1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			slot_r <= '0;
			scan_r <= 3'h0;
		end else begin
			slot_r <= slot_nxt;
			scan_r <= scan_nxt;
		end
	end

	// ==========================================================
	// output drive, registered
	logic [ldm_pkg::NUM_BP-1:0]  bp_nxt;
	logic [ldm_pkg::NUM_SEG-1:0] seg_nxt;
	logic [ldm_pkg::NUM_SEG-1:0] act_nxt;
	logic [ldm_pkg::NUM_GP-1:0]  gen_nxt;
	logic                        row_live;
	// a row left over from a wider mode stays dark until its slot ends
	assign row_live = ({1'b0, scan_r} < num_rows);
	assign gen_nxt  = general_enable & general_level;
	always_comb begin
		bp_nxt = '0;
		bp_nxt[scan_r] = row_live;
	end
	for (genvar s = 0; s < ldm_pkg::NUM_SEG; s++) begin : g_seg
		logic gp_taken;
		if (s < ldm_pkg::NUM_GP) begin : g_gp
			assign gp_taken = general_enable[s];
		end else begin : g_nogp
			assign gp_taken = 1'b0;
		end
		// column inside mode range and not taken by a general output
		assign act_nxt[s] = (6'(s) < num_cols) && !gp_taken;
		// held bit of this column at the scanned row
		assign seg_nxt[s] = act_nxt[s] && row_live && image[s*ldm_pkg::NUM_BP + int'(scan_r)];
	end
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			backplane_out  <= '0;
			segment_out    <= '0;
			segment_active <= '0;
			general_out    <= '0;
		end else begin
			backplane_out  <= bp_nxt;
			segment_out    <= seg_nxt;
			segment_active <= act_nxt;
			general_out    <= gen_nxt;
		end
	end

	// ==========================================================
	// checks
	// no backplane above the active count once the mode has settled
	a_bp_in_range: assert property (@(posedge ref_clk) disable iff (!resetn)
		$stable(mux_mode) |-> ((backplane_out >> num_rows) == '0))
		else $error("backplane beyond active count");
	a_seg_gp_mask: assert property (@(posedge ref_clk) disable iff (!resetn)
		$past(general_enable[0]) && $past(resetn) |-> !segment_active[0])
		else $error("general output segment still active");
	a_ptr_stops: assert property (@(posedge ref_clk) disable iff (!resetn)
		at_end && !ptr_load |=> col_r == $past(col_r))
		else $error("pointer moved past end");
	a_no_wr_end: assert property (@(posedge ref_clk) disable iff (!resetn)
		at_end |-> !wr_en)
		else $error("write past end of memory");
	a_ptr_load: assert property (@(posedge ref_clk) disable iff (!resetn)
		ptr_load |=> col_r == $past(ptr_value) && row_r == 3'h0)
		else $error("pointer load not taken");
	// a byte takes eight write cycles unless a pointer load cuts it short
	a_byte_len: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_r == ldm_pkg::LDM_IDLE) ##1 (st_r == ldm_pkg::LDM_WRITE) |->
		((st_r == ldm_pkg::LDM_WRITE)[*8] ##1 (st_r == ldm_pkg::LDM_IDLE)) or (##[0:7] ptr_load))
		else $error("byte not eight bits");
	// scan moves one row up inside the active rows, or back to row zero
	a_scan_range: assert property (@(posedge ref_clk) disable iff (!resetn)
		(slot_r == '0) && $changed(scan_r) |->
		(scan_r == 3'h0) || ((scan_r == $past(scan_r) + 3'h1) && ({1'b0, scan_r} < num_rows)))
		else $error("scan order broken");
	a_seg_off_range: assert property (@(posedge ref_clk) disable iff (!resetn)
		num_cols == 6'(ldm_pkg::COLS_MUX8) && $stable(mux_mode) |=> !segment_out[43])
		else $error("segment outside mode range driven");
	// general outputs follow enable and level one cycle later
	a_gp_level: assert property (@(posedge ref_clk) disable iff (!resetn)
		$past(resetn) |-> (general_out == $past(general_enable & general_level)))
		else $error("general output level wrong");
	// the buffer never takes a third byte, so none is overwritten
	a_buf_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
		(buf_cnt_r != 2'h3) && !(buf_push && (buf_cnt_r == 2'h2)))
		else $error("byte buffer overrun");
endmodule
`default_nettype wire

//--- hw/ldm_pkg.sv
// ldm_pkg: constants shared by the lcd display ram multiplexer and its ram.
// assumes: single 250 mhz clock domain, synchronous active-low reset.
`default_nettype none
package ldm_pkg;
	// ==========================================================
	// geometry
	localparam int NUM_BP      = 8;
	localparam int NUM_SEG     = 44;
	localparam int NUM_GP      = 6;
	localparam int PTR_W       = 6;
	localparam int ROW_W       = 3;
	localparam int COLS_MUX8   = 40;
	localparam int COLS_MUX6   = 42;
	localparam int COLS_MUX4   = 44;
	localparam int ROWS_MUX8   = 8;
	localparam int ROWS_MUX6   = 6;
	localparam int ROWS_MUX4   = 4;
	// ==========================================================
	// reset values and timing
	localparam logic [PTR_W-1:0] PTR_RST    = 6'h00;
	localparam int               CLK_MHZ    = 250;
	localparam int               SLOT_US    = 20;   // backplane slot time, plain default
	localparam int               SLOT_CYC   = SLOT_US * CLK_MHZ;
	// ==========================================================
	// multiplex modes and write engine states
	typedef enum logic [2:0] {
		LDM_MUX4 = 3'b001,
		LDM_MUX6 = 3'b010,
		LDM_MUX8 = 3'b100
	} ldm_mode_e;
	typedef enum logic [1:0] {
		LDM_IDLE  = 2'b01,
		LDM_WRITE = 2'b10
	} ldm_state_e;
endpackage
`default_nettype wire

//--- hw/ldm_ram.sv
// ldm_ram: 44 columns by 8 rows display memory, per-bit write, full image out.
// assumes: written by the multiplexer top; contents survive reset.
`timescale 1ns/1ps
`default_nettype none
module ldm_ram #(
	parameter int COLS = 44,
	parameter int ROWS = 8
) (
	input  wire logic                       ref_clk,
	input  wire logic                       wr_en,
	input  wire logic [5:0]                 wr_col,
	input  wire logic [2:0]                 wr_row,
	input  wire logic                       wr_bit,
	output var  logic [COLS*ROWS-1:0]       image
);
	// ==========================================================
	// storage, no reset so display data stays put
	logic [COLS*ROWS-1:0] mem_r;
	logic [COLS*ROWS-1:0] mem_nxt;
	always_comb begin
		mem_nxt = mem_r;
		if (wr_en && (int'(wr_col) < COLS))
			mem_nxt[int'(wr_col)*ROWS + int'(wr_row)] = wr_bit;
	end
	always_ff @(posedge ref_clk) begin
		mem_r <= mem_nxt;
	end
	assign image = mem_r;
endmodule
`default_nettype wire

//--- tb/ldm_host.sv
// ldm_host: host side model that loads the write pointer and offers bytes.
// assumes: byte_ready is settled at the falling edge; inputs move on it.
`timescale 1ns/1ps
`default_nettype none
module ldm_host (
	input  wire logic       ref_clk,
	input  wire logic       byte_ready,
	output logic            ptr_load,
	output logic [5:0]      ptr_value,
	output logic            byte_valid,
	output logic [7:0]      byte_data
);
	int stalls = 0;
	// idle bus at time zero
	initial begin
		ptr_load = 1'b0;
		ptr_value = 6'h00;
		byte_valid = 1'b0;
		byte_data = 8'h00;
	end
	// ==========================================================
	// pointer load, issued before every new run of bytes
	task automatic load_ptr(input logic [5:0] col);
		@(negedge ref_clk);
		ptr_load = 1'b1;
		ptr_value = col;
		@(negedge ref_clk);
		ptr_load = 1'b0;
		ptr_value = ~col; // stale value never shows
	endtask
	// ==========================================================
	// one byte, held until a rising edge sees ready high
	task automatic send(input logic [7:0] b);
		@(negedge ref_clk);
		byte_valid = 1'b1;
		byte_data = b;
		while (byte_ready !== 1'b1) begin
			stalls++;
			@(negedge ref_clk);
		end
		@(posedge ref_clk);
		@(negedge ref_clk);
		byte_valid = 1'b0;
		byte_data = ~b;
	endtask
endmodule
`default_nettype wire

//--- tb/ldm_mux_bench.sv
// ldm_mux_bench: self-checking bench, judges memory through the scan.
// assumes: ldm_pkg and ldm_mux compiled first; short slot for speed.
`timescale 1ns/1ps
`default_nettype none
module ldm_mux_bench;
	logic        ref_clk = 1'b0;
	logic        resetn;
	logic [2:0]  mux_mode;
	logic [5:0]  gp_en;
	logic [5:0]  gp_lv;
	logic        ptr_load;
	logic [5:0]  ptr_value;
	logic        byte_valid;
	logic        byte_ready;
	logic [7:0]  byte_data;
	logic [7:0]  backplane_out;
	logic [43:0] segment_out;
	logic [43:0] segment_active;
	logic [5:0]  general_out;
	logic [5:0]  write_pointer;
	logic [7:0]  exp_m [44];
	logic [7:0]  wm [44];
	int          col, row, ncol, nrow, cyc;
	int          bad_count = 0;
	int          tests_run = 0;
	// clock, 4 ns period
	always #2 ref_clk = ~ref_clk;
	ldm_mux #(.SLOT_CYCLES(4)) dut_u (.ref_clk(ref_clk), .resetn(resetn), .mux_mode(mux_mode),
		.ptr_load(ptr_load), .ptr_value(ptr_value), .byte_valid(byte_valid), .byte_ready(byte_ready),
		.byte_data(byte_data), .general_enable(gp_en), .general_level(gp_lv),
		.backplane_out(backplane_out), .segment_out(segment_out), .segment_active(segment_active),
		.general_out(general_out), .write_pointer(write_pointer));
	ldm_host host_u (.ref_clk(ref_clk), .byte_ready(byte_ready), .ptr_load(ptr_load),
		.ptr_value(ptr_value), .byte_valid(byte_valid), .byte_data(byte_data));
	// ==========================================================
	// helpers
	task automatic end_sim();
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic setm(input logic [2:0] m, input int nc, input int nr);
		@(negedge ref_clk);
		mux_mode = m;
		ncol = nc;
		nrow = nr;
	endtask
	task automatic load(input logic [5:0] c);
		col = c;
		row = 0;
		host_u.load_ptr(c);
	endtask
	// expected placement: msb first, rows then next column, drop past end
	task automatic put(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			if (col < ncol) begin
				exp_m[col][row] = b[i];
				wm[col][row] = 1'b1;
				row++;
				if (row == nrow) begin
					row = 0;
					col++;
				end
			end
		end
		host_u.send(b);
	endtask
	// walk the scan and compare every written, active bit
	task automatic check_all();
		logic [43:0] act;
		int n;
		repeat (30) @(negedge ref_clk); // let the buffer drain
		for (int c = 0; c < 44; c++)
			act[c] = (c < ncol) && !(c < 6 && gp_en[c]);
		chk(write_pointer === 6'(col), "pointer");
		chk(general_out === (gp_en & gp_lv), "general out");
		for (int r = 0; r < nrow; r++) begin
			n = 0;
			while (backplane_out !== 8'(1 << r) && n < 200) begin
				n++;
				@(negedge ref_clk);
			end
			chk(n < 200, "backplane scan");
			chk((backplane_out >> nrow) === 8'h00, "idle backplane driven");
			chk(segment_active === act, "active segments");
			for (int c = 0; c < 44; c++)
				if (act[c] && wm[c][r]) chk(segment_out[c] === exp_m[c][r], "segment data");
		end
	endtask
	// ==========================================================
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	// ==========================================================
	// scenarios
	// power-up reset: outputs quiet, scan starts at row zero after release
	task automatic t_reset();
		resetn = 1'b0;
		mux_mode = ldm_pkg::LDM_MUX8;
		gp_en = 6'h29;
		gp_lv = 6'h0f;
		for (int c = 0; c < 44; c++)
			wm[c] = 8'h00;
		repeat (10) @(negedge ref_clk);
		chk(write_pointer === 6'h00 && backplane_out === 8'h00 && general_out === 6'h00, "reset");
		chk(segment_out === 44'h0 && segment_active === 44'h0, "reset segments");
		resetn = 1'b1;
		@(negedge ref_clk);
		chk(backplane_out === 8'h01, "first backplane after reset");
	endtask
	// 1:8 fill one byte past the end, under back pressure
	task automatic t_fill_mux8();
		setm(ldm_pkg::LDM_MUX8, 40, 8);
		load(6'h00);
		for (int i = 0; i < 41; i++)
			put(8'(i * 37 + 5));
		chk(host_u.stalls > 0, "buffer never full");
		check_all();
	endtask
	// 1:4 run spilling past the last column, other general outputs
	task automatic t_edge_mux4();
		setm(ldm_pkg::LDM_MUX4, 44, 4);
		gp_en = 6'h16;
		gp_lv = 6'h35;
		load(6'h28);
		put(8'hc3);
		put(8'h5a);
		put(8'hff);
		check_all();
	endtask
	// 1:6 end of memory, then a wrapped pair from column zero
	task automatic t_wrap_mux6();
		setm(ldm_pkg::LDM_MUX6, 42, 6);
		load(6'h29);
		put(8'h3c);
		put(8'h81);
		check_all();
		load(6'h00);
		put(8'ha5);
		put(8'h96);
		check_all();
	endtask
	// reset in mid-run keeps the memory and restarts pointer and scan
	task automatic t_mid_reset();
		@(negedge ref_clk);
		resetn = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(write_pointer === 6'h00 && backplane_out === 8'h00, "mid-run reset");
		resetn = 1'b1;
		col = 0;
		row = 0;
		@(negedge ref_clk);
		chk(backplane_out === 8'h01, "scan restart after reset");
		check_all();
	endtask
	// ==========================================================
	// main sequence
	initial begin
		t_reset();
		t_fill_mux8();
		t_edge_mux4();
		t_wrap_mux6();
		t_mid_reset();
		end_sim();
	end
endmodule
`default_nettype wire
